// ---- src/scsm_regs.vh ----
// Register offsets, reset values, fields and codes for the socket command block
`ifndef SCSM_REGS_VH
`define SCSM_REGS_VH
// ----------------------------------------
// Register offsets (socket 0 base; socket n adds n*0x100)
// ----------------------------------------
`define SCSM_OFS_MODE 16'h4000
`define SCSM_OFS_CMD 16'h4001
`define SCSM_OFS_EVT 16'h4002
`define SCSM_OFS_STATE 16'h4003
`define SCSM_SOCK_STRIDE_BIT 8
`define SCSM_MODE_RST 8'h00
`define SCSM_CMD_RST 8'h00
`define SCSM_EVT_RST 8'h00
// ----------------------------------------
// Fields
// ----------------------------------------
`define SCSM_PROTO_MSB 3
`define SCSM_PROTO_LSB 0
`define SCSM_EVT_CONNECT 0
`define SCSM_EVT_CLOSED 1
`define SCSM_EVT_TIMEOUT 3
`define SCSM_EVT_SENT 4
// ----------------------------------------
// Command codes
// ----------------------------------------
`define SCSM_CMD_OPEN 8'h01
`define SCSM_CMD_LISTEN 8'h02
`define SCSM_CMD_CONNECT 8'h04
`define SCSM_CMD_DISCONNECT 8'h08
`define SCSM_CMD_CLOSE 8'h10
`define SCSM_CMD_SEND 8'h20
// ----------------------------------------
// Protocol codes
// ----------------------------------------
`define SCSM_PROTO_NONE 4'h0
`define SCSM_PROTO_STREAM 4'h1
`define SCSM_PROTO_DATAGRAM 4'h2
`define SCSM_PROTO_RAW_IP 4'h3
`define SCSM_PROTO_RAW_FRAME 4'h4
`define SCSM_PROTO_PPP 4'h5
// ----------------------------------------
// Socket state codes
// ----------------------------------------
`define SCSM_ST_CLOSED 8'h00
`define SCSM_ST_INIT 8'h13
`define SCSM_ST_LISTEN 8'h14
`define SCSM_ST_SYNSENT 8'h15
`define SCSM_ST_CONNECTED 8'h17
`define SCSM_ST_FINWAIT 8'h18
`define SCSM_ST_DATAGRAM 8'h22
`define SCSM_ST_RAW_IP 8'h32
`define SCSM_ST_RAW_FRAME 8'h42
`define SCSM_ST_PPP 8'h5f
`endif

// ---- src/scsm_sync.v ----
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module scsm_sync #(
    parameter W = 1
) (
    input wire ref_clk,
    input wire resetn,
    input wire clkEn,
    input wire [W-1:0] asyncIn,
    output reg [W-1:0] syncOut
);
    reg [W-1:0] stage1Reg;
    always @(posedge ref_clk) begin
        if (!resetn) begin
            stage1Reg <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else if (clkEn) begin
            stage1Reg <= asyncIn;
            syncOut <= stage1Reg;
        end
    end
endmodule // scsm_sync

// ---- src/scsm_socket.v ----
// One socket: command register, state machine and event flags
`timescale 1ns/1ps
`include "scsm_regs.vh"
module scsm_socket #(
    parameter [2:0] SOCK_ID = 3'h0
) (
    input wire ref_clk,
    input wire resetn,
    input wire clkEn,
    input wire modeWr,
    input wire cmdWr,
    input wire evtWr,
    input wire [7:0] wrData,
    input wire [7:0] linkEvt,
    output reg [7:0] modeReg,
    output reg [7:0] cmdReg,
    output reg [7:0] evtReg,
    output reg [7:0] stateReg,
    output reg synReq,
    output reg finReq,
    output reg rstReq,
    output reg sendReq
);
    // ----------------------------------------
    // Link events (synchronised), one bit each
    // ----------------------------------------
    wire evConnOk = linkEvt[0];
    wire evSynAckFail = linkEvt[1];
    wire evArpTo = linkEvt[2];
    wire evTcpTo = linkEvt[3];
    wire evRst = linkEvt[4];
    wire evFinRx = linkEvt[5];
    wire evFinAck = linkEvt[6];
    wire evNoPort = linkEvt[7];
    wire [3:0] proto = modeReg[`SCSM_PROTO_MSB:`SCSM_PROTO_LSB];
    wire isStream = (proto == `SCSM_PROTO_STREAM);
    reg [7:0] stateNext;
    reg [7:0] evtSet;
    reg finSentReg;
    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always @* begin
        stateNext = stateReg;
        evtSet = 8'h00;
        if (cmdReg == `SCSM_CMD_OPEN) begin
            case (proto)
                `SCSM_PROTO_STREAM: stateNext = `SCSM_ST_INIT;
                `SCSM_PROTO_DATAGRAM: stateNext = `SCSM_ST_DATAGRAM;
                `SCSM_PROTO_RAW_IP: stateNext = `SCSM_ST_RAW_IP;
                `SCSM_PROTO_RAW_FRAME:
                    if (SOCK_ID == 3'h0) stateNext = `SCSM_ST_RAW_FRAME;
                `SCSM_PROTO_PPP:
                    if (SOCK_ID == 3'h0) stateNext = `SCSM_ST_PPP;
                default: stateNext = stateReg;
            endcase
        end else if (cmdReg == `SCSM_CMD_CLOSE) begin
            stateNext = `SCSM_ST_CLOSED;
        end else if (cmdReg == `SCSM_CMD_LISTEN) begin
            if (isStream && stateReg == `SCSM_ST_INIT) stateNext = `SCSM_ST_LISTEN;
        end else if (cmdReg == `SCSM_CMD_CONNECT) begin
            if (isStream && stateReg == `SCSM_ST_INIT) stateNext = `SCSM_ST_SYNSENT;
        end else if (cmdReg == `SCSM_CMD_DISCONNECT) begin
            if (isStream && stateReg == `SCSM_ST_CONNECTED) stateNext = `SCSM_ST_FINWAIT;
        end else begin
            case (stateReg)
                `SCSM_ST_LISTEN:
                    if (evConnOk) begin
                        stateNext = `SCSM_ST_CONNECTED;
                        evtSet[`SCSM_EVT_CONNECT] = 1'b1;
                    end else if (evSynAckFail) begin
                        stateNext = `SCSM_ST_CLOSED;
                        evtSet[`SCSM_EVT_TIMEOUT] = 1'b1;
                    end
                `SCSM_ST_SYNSENT:
                    if (evConnOk) begin
                        stateNext = `SCSM_ST_CONNECTED;
                        evtSet[`SCSM_EVT_CONNECT] = 1'b1;
                    end else if (evArpTo || evTcpTo) begin
                        stateNext = `SCSM_ST_CLOSED;
                        evtSet[`SCSM_EVT_TIMEOUT] = 1'b1;
                    end else if (evRst) begin
                        stateNext = `SCSM_ST_CLOSED;
                    end
                `SCSM_ST_CONNECTED:
                    if (evRst) begin
                        stateNext = `SCSM_ST_CLOSED;
                        evtSet[`SCSM_EVT_CLOSED] = 1'b1;
                    end else if (evFinRx) begin
                        stateNext = `SCSM_ST_FINWAIT;
                    end
                `SCSM_ST_FINWAIT:
                    if (evFinAck || evRst) begin
                        stateNext = `SCSM_ST_CLOSED;
                        evtSet[`SCSM_EVT_CLOSED] = 1'b1;
                    end else if (evTcpTo) begin
                        stateNext = `SCSM_ST_CLOSED;
                        evtSet[`SCSM_EVT_TIMEOUT] = 1'b1;
                    end
                default: stateNext = stateReg;
            endcase
        end
    end
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            modeReg <= `SCSM_MODE_RST;
            cmdReg <= `SCSM_CMD_RST;
            evtReg <= `SCSM_EVT_RST;
            stateReg <= `SCSM_ST_CLOSED;
            synReq <= 1'b0;
            finReq <= 1'b0;
            rstReq <= 1'b0;
            sendReq <= 1'b0;
            finSentReg <= 1'b0;
        end else if (clkEn) begin
            if (modeWr) modeReg <= wrData;
            // Accepted byte is consumed one cycle after the write
            if (cmdWr) cmdReg <= wrData;
            else cmdReg <= `SCSM_CMD_RST;
            // Set beats clear in the same cycle
            if (evtWr) evtReg <= (evtReg & ~wrData) | evtSet;
            else evtReg <= evtReg | evtSet;
            stateReg <= stateNext;
            // SYN must follow every move to SYN sent, even with a new write behind it
            synReq <= cmdReg == `SCSM_CMD_CONNECT
                && stateNext == `SCSM_ST_SYNSENT && stateReg == `SCSM_ST_INIT;
            // FIN once per close, whether active or answering a peer FIN
            finReq <= stateNext == `SCSM_ST_FINWAIT && !finSentReg;
            finSentReg <= stateNext == `SCSM_ST_FINWAIT;
            // Unknown destination port: RST out, state untouched
            rstReq <= evNoPort;
            sendReq <= !cmdWr && cmdReg == `SCSM_CMD_SEND
                && stateReg != `SCSM_ST_CLOSED;
        end
    end
endmodule // scsm_socket

// ---- src/scsm_top.v ----
// Socket command interpreter: eight sockets behind one byte register port
// Functional notes
// - Accepted command byte self-clears to 0x00.
// - Command runs on after clear; host judges by flags or state.
// - 0x01 opens socket per mode protocol field.
// - Open gives 0x13 stream, 0x22 datagram, 0x32 raw IP.
// - Open gives 0x42 raw frame, 0x5F PPP; none protocol no change.
// - 0x02, stream only, moves initialised to listening.
// - Listener connect success: connected, flag bit 0.
// - Listener SYN/ACK failure: flag bit 3, closed.
// - Request to missing port: RST reply, state unchanged.
// - 0x04, stream only, sends SYN to destination registers.
// - Client connect success: connected, flag bit 0.
// - Client aborts to closed on ARP timeout, TCP timeout, RST.
// - 0x08 sends FIN actively or answers peer FIN; here a peer FIN is answered without 0x08.
// - Disconnect closes on FIN/ACK, or timeout flag then closed.
// - Peer RST during communication always closes; here an RST in the same cycle as command 0x01, 0x02, 0x04 or 0x08 is lost.
// - 0x10 closes at once without exchange.
// - Send transmits all buffered transmit data.
// - Send code 0x20, extent set by transmit pointers.
// - Raw frame and PPP protocols only on socket 0.
// - Event flags stay set until host writes one.
// - Flag bit 3 marks address or transport timeout.
`timescale 1ns/1ps
`include "scsm_regs.vh"
module scsm_top (
    input wire ref_clk,
    input wire resetn,
    input wire clkEn,
    input wire regWe,
    input wire regRe,
    input wire [15:0] regAddr,
    input wire [7:0] regWrData,
    output reg [7:0] regRdData,
    input wire [63:0] linkEvtPin,
    output wire [7:0] synReq,
    output wire [7:0] finReq,
    output wire [7:0] rstReq,
    output wire [7:0] sendReq
);
    // ----------------------------------------
    // Link event inputs come from another domain
    // ----------------------------------------
    wire [63:0] linkEvt;
    scsm_sync #(.W(64)) uSync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clkEn(clkEn),
        .asyncIn(linkEvtPin),
        .syncOut(linkEvt)
    );
    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    wire [2:0] sockSel = regAddr[`SCSM_SOCK_STRIDE_BIT+2:`SCSM_SOCK_STRIDE_BIT];
    wire [15:0] baseAddr = {regAddr[15:`SCSM_SOCK_STRIDE_BIT+3], 3'h0, regAddr[7:0]};
    wire inWin = regAddr[`SCSM_SOCK_STRIDE_BIT+3+1:`SCSM_SOCK_STRIDE_BIT+3] == 2'h0;
    wire [63:0] modeQ;
    wire [63:0] cmdQ;
    wire [63:0] evtQ;
    wire [63:0] stateQ;
    genvar s;
    generate
        for (s = 0; s < 8; s = s + 1) begin : gSock
            wire hit = regWe && inWin && sockSel == s;
            scsm_socket #(.SOCK_ID(s)) uSock (
                .ref_clk(ref_clk),
                .resetn(resetn),
                .clkEn(clkEn),
                .modeWr(hit && baseAddr == `SCSM_OFS_MODE),
                .cmdWr(hit && baseAddr == `SCSM_OFS_CMD),
                .evtWr(hit && baseAddr == `SCSM_OFS_EVT),
                .wrData(regWrData),
                .linkEvt(linkEvt[8*s+7:8*s]),
                .modeReg(modeQ[8*s+7:8*s]),
                .cmdReg(cmdQ[8*s+7:8*s]),
                .evtReg(evtQ[8*s+7:8*s]),
                .stateReg(stateQ[8*s+7:8*s]),
                .synReq(synReq[s]),
                .finReq(finReq[s]),
                .rstReq(rstReq[s]),
                .sendReq(sendReq[s])
            );
        end
    endgenerate
    // ----------------------------------------
    // Read data, registered; unmapped reads zero
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!resetn) begin
            regRdData <= 8'h00;
        end else if (clkEn && regRe) begin
            if (!inWin) regRdData <= 8'h00;
            else if (baseAddr == `SCSM_OFS_MODE) regRdData <= modeQ[8*sockSel+:8];
            else if (baseAddr == `SCSM_OFS_CMD) regRdData <= cmdQ[8*sockSel+:8];
            else if (baseAddr == `SCSM_OFS_EVT) regRdData <= evtQ[8*sockSel+:8];
            else if (baseAddr == `SCSM_OFS_STATE) regRdData <= stateQ[8*sockSel+:8];
            else regRdData <= 8'h00;
        end
    end
endmodule // scsm_top

// ---- tb/scsm_top_assertions.sv ----
// Port checker for the socket command interpreter
`timescale 1ns/1ps
module scsm_top_assertions (
    input wire ref_clk,
    input wire resetn,
    input wire clkEn,
    input wire regWe,
    input wire regRe,
    input wire [15:0] regAddr,
    input wire [7:0] regWrData,
    input wire [7:0] regRdData,
    input wire [63:0] linkEvtPin,
    input wire [7:0] synReq,
    input wire [7:0] finReq,
    input wire [7:0] rstReq,
    input wire [7:0] sendReq
);
    // ----------------------------------------
    // Command bytes written to socket 0 in each of the last four cycles, zero where none
    // ----------------------------------------
    reg [31:0] hist_reg;
    wire [7:0] cmdVal = (regWe && regAddr == 16'h4001) ? regWrData : 8'h00;
    wire [2:0] reqV = {synReq[0], finReq[0], sendReq[0]};
    always @(posedge ref_clk) begin
        hist_reg <= resetn ? {hist_reg[23:0], cmdVal} : 32'h0;
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    a_cmd_self_clear: assert property (
        regRe && regAddr == 16'h4001 && cmdVal == 8'h00 && hist_reg[23:0] == 24'h0
        |=> regRdData == 8'h00) else $error("command byte still set");
    a_syn_cause: assert property (
        synReq[0] |-> hist_reg[7:0] == 8'h04 || hist_reg[15:8] == 8'h04
        || hist_reg[23:16] == 8'h04) else $error("connect request without command");
    a_fin_cause: assert property (
        finReq[0] |-> hist_reg[15:8] == 8'h08 || hist_reg[23:16] == 8'h08
        || hist_reg[31:24] == 8'h08 || $past(linkEvtPin[5], 3))
        else $error("close request without command or peer FIN");
    a_send_cause: assert property (
        sendReq[0] |-> hist_reg[7:0] == 8'h20 || hist_reg[15:8] == 8'h20
        || hist_reg[23:16] == 8'h20) else $error("transmit request without command");
    a_req_one_cycle: assert property (
        |reqV |=> (reqV & $past(reqV)) == 3'h0) else $error("request longer than one cycle");
    a_rst_reply: assert property (
        $rose(linkEvtPin[7]) |-> ##[1:4] rstReq[0]) else $error("no reset reply");
    a_read_holds: assert property (
        !$past(regRe) |-> $stable(regRdData)) else $error("read data moved");
    a_reset_quiet: assert property (
        $rose(resetn) |-> {synReq, finReq, rstReq, sendReq} == 32'h0)
        else $error("request active after reset");
endmodule // scsm_top_assertions
bind scsm_top scsm_top_assertions chk (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn),
    .regWe(regWe), .regRe(regRe), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .linkEvtPin(linkEvtPin), .synReq(synReq), .finReq(finReq),
    .rstReq(rstReq), .sendReq(sendReq));

// ---- tb/scsm_net_model.sv ----
// Network engine stand-in driving the link event pins of socket 0
`timescale 1ns/1ps
module scsm_net_model (
    input wire ref_clk,
    input wire [7:0] synReq,
    input wire [2:0] answer,
    input wire slow,
    output reg [63:0] linkEvtPin
);
    initial linkEvtPin = 64'h0;
    // Held two cycles so the two-flop sync cannot miss it; idle low after
    task fire(input integer sock, input integer b);
        linkEvtPin[8 * sock + b] = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        linkEvtPin[8 * sock + b] = 1'b0;
    endtask
    // Connect answered after a short or a long flight time
    always @(posedge ref_clk) begin
        if (synReq[0]) begin
            repeat (slow ? 20 : 3) @(posedge ref_clk);
            #1;
            fire(0, answer);
        end
    end
endmodule // scsm_net_model

// ---- tb/tb_scsm_top.sv ----
// Self-checking bench for the socket command interpreter
`timescale 1ns/1ps
`include "scsm_regs.vh"
module tb_scsm_top;
    localparam [47:0] OPEN_ST = {`SCSM_ST_PPP, `SCSM_ST_RAW_FRAME, `SCSM_ST_RAW_IP,
        `SCSM_ST_DATAGRAM, `SCSM_ST_INIT, `SCSM_ST_CLOSED};
    localparam [15:0] ST = `SCSM_OFS_STATE;
    localparam [15:0] EV = `SCSM_OFS_EVT;
    reg ref_clk, resetn, regWe, regRe, slow, rdSeen, clkEn;
    reg [15:0] regAddr, b;
    reg [7:0] regWrData, e8;
    reg [2:0] answer;
    wire [7:0] regRdData, synReq, finReq, rstReq, sendReq;
    wire [63:0] linkEvtPin;
    reg [7:0] expQ[$];
    reg [15:0] adrQ[$];
    reg [3:0] reqExpQ[$];
    reg [3:0] reqPrev;
    wire [3:0] reqNow = {rstReq[0], sendReq[0], finReq[0], synReq[0]};
    wire [3:0] reqEdge = reqNow & ~reqPrev;
    integer err_count, checked, cycles, seed, i;
    scsm_top uut (.ref_clk(ref_clk), .resetn(resetn), .clkEn(clkEn), .regWe(regWe),
        .regRe(regRe), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
        .linkEvtPin(linkEvtPin), .synReq(synReq), .finReq(finReq), .rstReq(rstReq),
        .sendReq(sendReq));
    scsm_net_model net (.ref_clk(ref_clk), .synReq(synReq), .answer(answer), .slow(slow),
        .linkEvtPin(linkEvtPin));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task end_sim;
        $display("counts: %0d mismatches in %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmp(input [15:0] a, input [7:0] e, input [7:0] g);
        checked = checked + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED reg %h expected %h seen %h", a, e, g);
        end
    endtask
    task cmpReq(input [3:0] e, input [3:0] g);
        checked = checked + 1;
        if (g !== e) begin
            err_count = err_count + 1;
            $display("CHECK FAILED request expected %b seen %b", e, g);
        end
    endtask
    // Read data lands one cycle after the read edge
    always @(posedge ref_clk) begin
        if (rdSeen)
            cmp(adrQ.pop_front(), expQ.pop_front(), regRdData);
        rdSeen <= regRe;
        // Each new request edge takes the oldest expected request
        if (resetn && reqEdge != 4'h0)
            cmpReq(reqExpQ.size() ? reqExpQ.pop_front() : 4'h0, reqEdge);
        reqPrev <= reqNow;
        cycles = cycles + 1;
        if (cycles > 5000) begin
            err_count = err_count + 1;
            end_sim;
        end
    end
    // Strobes stay up between back-to-back ops; idle drops them
    task op(input we, input re, input [15:0] a, input [7:0] d);
        regWe = we;
        regRe = re;
        regAddr = a;
        regWrData = d;
        @(posedge ref_clk);
        #1;
    endtask
    task rd(input [15:0] a, input [7:0] e);
        adrQ.push_back(a);
        expQ.push_back(e);
        op(1'b0, 1'b1, a, 8'h00);
    endtask
    task idle(input integer n);
        regWe = 1'b0;
        regRe = 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task cmd(input [7:0] c);
        op(1'b1, 1'b0, `SCSM_OFS_CMD, c);
        idle(4);
    endtask
    task ev(input integer n);
        idle(1);
        net.fire(0, n);
        idle(4);
    endtask
    task open(input [3:0] p);
        op(1'b1, 1'b0, `SCSM_OFS_MODE, {4'h0, p});
        cmd(`SCSM_CMD_OPEN);
    endtask
    task client;
        open(`SCSM_PROTO_STREAM);
        cmd(`SCSM_CMD_CONNECT);
        idle(30);
    endtask
    initial begin
        seed = 26;
        {err_count, checked, cycles} = 0;
        {rdSeen, resetn, slow, answer, regAddr, regWrData} = 0;
        clkEn = 1'b1;
        idle(16);
        resetn = 1'b1;
        for (i = 0; i < 4; i = i + 1)
            rd(16'h4700 + i[15:0], 8'h00);
        op(1'b1, 1'b0, 16'h0010, 8'($random(seed)));
        op(1'b1, 1'b0, ST, 8'($random(seed)));
        rd(16'h0010, 8'h00);
        rd(ST, `SCSM_ST_CLOSED);
        $display("test reset done");
        for (i = 0; i < 12; i = i + 1) begin
            b = (i < 6) ? 16'h0000 : 16'h0100;
            e8 = (b != 0 && i % 6 > 3) ? 8'h00 : OPEN_ST[8 * (i % 6) +: 8];
            op(1'b1, 1'b0, `SCSM_OFS_MODE + b, 8'(i % 6));
            op(1'b1, 1'b0, `SCSM_OFS_CMD + b, `SCSM_CMD_OPEN);
            idle(4);
            rd(`SCSM_OFS_CMD + b, 8'h00);
            rd(ST + b, e8);
            op(1'b1, 1'b0, `SCSM_OFS_CMD + b, `SCSM_CMD_CLOSE);
            idle(4);
            rd(ST + b, `SCSM_ST_CLOSED);
        end
        $display("test open done");
        open(`SCSM_PROTO_STREAM);
        cmd(`SCSM_CMD_LISTEN);
        reqExpQ.push_back(4'h8);
        ev(7);
        rd(ST, `SCSM_ST_LISTEN);
        ev(0);
        rd(ST, `SCSM_ST_CONNECTED);
        rd(EV, 8'h01);
        op(1'b1, 1'b0, EV, 8'h01);
        rd(EV, 8'h00);
        reqExpQ.push_back(4'h4);
        cmd(`SCSM_CMD_SEND);
        reqExpQ.push_back(4'h2);
        cmd(`SCSM_CMD_DISCONNECT);
        ev(6);
        rd(ST, `SCSM_ST_CLOSED);
        open(`SCSM_PROTO_STREAM);
        cmd(`SCSM_CMD_LISTEN);
        op(1'b1, 1'b0, EV, 8'hff);
        ev(1);
        rd(ST, `SCSM_ST_CLOSED);
        rd(EV, 8'h08);
        $display("test server done");
        for (i = 0; i < 4; i = i + 1) begin
            op(1'b1, 1'b0, EV, 8'hff);
            answer = (i == 0) ? 3'h0 : 3'(i + 1);
            slow = i[0];
            reqExpQ.push_back(4'h1);
            client;
            rd(ST, i == 0 ? `SCSM_ST_CONNECTED : `SCSM_ST_CLOSED);
            rd(EV, i == 0 ? 8'h01 : (i == 3 ? 8'h00 : 8'h08));
        end
        // Peer reset must hit a live connection, not a closed socket
        op(1'b1, 1'b0, EV, 8'hff);
        answer = 3'h0;
        reqExpQ.push_back(4'h1);
        client;
        ev(4);
        rd(ST, `SCSM_ST_CLOSED);
        rd(EV, 8'h03);
        op(1'b1, 1'b0, EV, 8'hff);
        reqExpQ.push_back(4'h1);
        client;
        reqExpQ.push_back(4'h2);
        cmd(`SCSM_CMD_DISCONNECT);
        ev(3);
        rd(ST, `SCSM_ST_CLOSED);
        rd(EV, 8'h09);
        // Passive close: peer FIN answered by our own FIN
        op(1'b1, 1'b0, EV, 8'hff);
        reqExpQ.push_back(4'h1);
        client;
        reqExpQ.push_back(4'h2);
        ev(5);
        rd(ST, `SCSM_ST_FINWAIT);
        ev(6);
        rd(ST, `SCSM_ST_CLOSED);
        rd(EV, 8'h03);
        $display("test client done");
        open(`SCSM_PROTO_DATAGRAM);
        for (i = 0; i < 3; i = i + 1) begin
            cmd(8'h02 << i);
            rd(`SCSM_OFS_CMD, 8'h00);
            rd(ST, `SCSM_ST_DATAGRAM);
        end
        // Frozen clock enable: a close written now is lost
        clkEn = 1'b0;
        cmd(`SCSM_CMD_CLOSE);
        clkEn = 1'b1;
        rd(ST, `SCSM_ST_DATAGRAM);
        idle(2);
        cmpReq(4'h0, 4'(reqExpQ.size()));
        $display("test misfit commands done");
        end_sim;
    end
endmodule // tb_scsm_top
